/* tad_pkg.sv */
// shared constants and carrier types of the t3/e3 alarm detector
// assumes one 40 MHz receive clock shared with the framer logic
package tad_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [5:0] TAD_IDX_STATUS = 6'h12;
  localparam logic [5:0] TAD_IDX_MASK = 6'h14;
  localparam logic [5:0] TAD_IDX_INFO = 6'h16;
  localparam logic [5:0] TAD_IDX_CONFIG = 6'h18;

  // ==========================================================
  // field positions
  localparam int TAD_BIT_ALIGN_CHANGE = 0;
  localparam int TAD_BIT_CODEWORD = 1;
  localparam int TAD_BIT_FRAMING_ERR = 2;
  localparam int TAD_BIT_M_ERR = 3;
  localparam int TAD_BIT_EXCESS_ZERO = 4;
  localparam int TAD_BIT_RX_SOF = 6;
  localparam int TAD_BIT_E3_MODE = 0;
  localparam int TAD_BIT_UNIPOLAR = 1;

  // ==========================================================
  // reset values
  localparam logic [15:0] TAD_MASK_RESET = 16'h0000;
  localparam logic [1:0] TAD_CONFIG_RESET = 2'h0;

  // ==========================================================
  // detection counts
  localparam int TAD_PAT_FIELDS = 1024;
  localparam logic [2:0] TAD_PAT_ERR_LIMIT = 3'h4;
  localparam logic [7:0] TAD_LOS_ZEROS = 8'hc0;
  localparam logic [7:0] TAD_LOS_WINDOW = 8'hc0;
  localparam logic [7:0] TAD_EXZ_T3 = 8'h03;
  localparam logic [7:0] TAD_EXZ_E3 = 8'h04;
  localparam logic [4:0] TAD_F_ERR_LIMIT = 5'h03;
  localparam logic [4:0] TAD_M_ERR_LIMIT = 5'h02;
  localparam int TAD_RAI_FRAMES = 4;
  localparam int TAD_E3_LOF_BAD = 4;
  localparam int TAD_E3_LOF_GOOD = 3;
  localparam logic [3:0] TAD_E3_AIS_MAX_ZEROS = 4'h4;
  localparam logic [2:0] TAD_E3_ZERO_SAT = 3'h5;
  localparam int TAD_ALIGN_W = 11;

  // ==========================================================
  // alarm levels, bit order matches the status register
  typedef struct packed {
    logic idle;
    logic rai;
    logic ais;
    logic lof;
    logic los;
  } tad_alarm_t;

  // per-bit and per-frame strobes from the receive framer
  typedef struct packed {
    logic bit_en;
    logic mark;
    logic data;
    logic codeword;
    logic info_bit;
    logic info_first;
    logic info_last;
    logic c_valid;
    logic c_bit;
    logic c_last;
    logic c_sub3;
    logic f_valid;
    logic f_err;
    logic m_valid;
    logic m_err;
    logic x1;
    logic x2;
    logic fas_valid;
    logic fas_ok;
    logic bit11;
    logic frame_start;
    logic sync;
    logic [TAD_ALIGN_W-1:0] align;
  } tad_rx_t;

endpackage : tad_pkg

/* tad_run_counter.sv */
// consecutive-event counter: pulses done on the LIMIT-th hit in a row
// assumes step and hit are one-cycle strobes on ref_clk
module tad_run_counter #(
  parameter int LIMIT = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic step,
  input wire logic hit,
  output logic done
);

  localparam int W = $clog2(LIMIT);
  localparam logic [W-1:0] LAST = W'(LIMIT - 1);

  logic [W-1:0] cnt_reg;

  // ==========================================================
  // done on the final hit of the run
  assign done = step & hit & (cnt_reg == LAST) & ~clr;

  // restart on a miss, a clear or a completed run
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (clr || done || (step && !hit)) begin
      cnt_reg <= '0;
    end else if (step && hit) begin
      cnt_reg <= cnt_reg + W'(1);
    end
  end

endmodule : tad_run_counter

/* tad_alarm_detector.sv */
// receive-side t3/e3 alarm and event detector with wishbone registers
// assumes framer strobes share ref_clk; wishbone classic slave
//
// Behaviour
// [RQ1] t3 ais set: 1024 good 10 fields
// [RQ2] t3 ais clear: 1024 fields with errors
// [RQ3] los after 192 zeros; clear window
// [RQ4] no los in unipolar mode
// [RQ5] t3 lof on f/m errors; sync clears
// [RQ6] t3 rai from x1 x2, four frames
// [RQ7] t3 idle set: 1024 good 1100 fields
// [RQ8] t3 idle clear: 1024 errored fields
// [RQ9] e3 ais set: few zeros, two frames
// [RQ10] e3 ais clear: five zeros, two frames
// [RQ11] e3 lof: four bad, three good fas
// [RQ12] e3 rai from bit 11, four frames
// [RQ13] info events raise no interrupt
// [RQ14] alignment change latches, clears on read
// [RQ15] alignment change only after resync
// [RQ16] codeword event latches, clears on read
// [RQ17] framing error event, clears on read
// [RQ18] m-bit error event in t3 only
// [RQ19] excess zero event per zero run
// [RQ20] mask bit 6 gates frame start request
// [RQ21] frame start status latches, clear on read
// [RQ22] synchronous detectors, inactive after reset
module tad_alarm_detector
  import tad_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire tad_rx_t rx,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output tad_alarm_t alarm_o,
  output logic rx_sof_req_o
);

  // ==========================================================
  // functions
  function automatic logic [4:0] popcnt(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction : popcnt

  function automatic logic [2:0] sat_err(input logic [2:0] c, input logic inc);
    return (c >= TAD_PAT_ERR_LIMIT) ? TAD_PAT_ERR_LIMIT : c + {2'h0, inc};
  endfunction : sat_err

  // ==========================================================
  // registers
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [15:0] mask_reg;
  logic [1:0] cfg_reg;
  logic [4:0] info_reg;
  logic sof_reg;
  logic sof_req_reg;
  tad_alarm_t alarm_reg;
  logic sync_d_reg;
  logic synced_reg;
  logic [TAD_ALIGN_W-1:0] align_reg;
  logic [1:0] pos_reg;
  logic [2:0] ten_err_reg;
  logic [2:0] quad_err_reg;
  logic [1:0] c_ones_reg;
  logic [15:0] f_win_reg;
  logic [3:0] m_win_reg;
  logic [7:0] run_reg;
  logic [7:0] win_reg;
  logic arm_reg;
  logic [2:0] zcur_reg;
  logic [2:0] zprev_reg;
  logic zprev_ok_reg;

  logic e3;
  logic unip;
  assign e3 = cfg_reg[TAD_BIT_E3_MODE];
  assign unip = cfg_reg[TAD_BIT_UNIPOLAR];

  // ==========================================================
  // wishbone decode
  logic acc;
  logic rd_status;
  logic rd_info;
  logic wr_mask;
  logic wr_cfg;
  logic [5:0] idx;
  assign idx = wb_adr_i[7:2];
  assign acc = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign rd_status = acc & ~wb_we_i & (idx == TAD_IDX_STATUS);
  assign rd_info = acc & ~wb_we_i & (idx == TAD_IDX_INFO);
  assign wr_mask = acc & wb_we_i & (idx == TAD_IDX_MASK);
  assign wr_cfg = acc & wb_we_i & (idx == TAD_IDX_CONFIG);

  // read mux, unmapped reads return zero
  logic [15:0] rd_data;
  always_comb begin
    rd_data = 16'h0000;
    case (idx)
      TAD_IDX_STATUS: begin
        rd_data = {9'h000, sof_reg, 1'b0, alarm_reg};
      end
      TAD_IDX_MASK: begin
        rd_data = mask_reg;
      end
      TAD_IDX_INFO: begin
        rd_data = {11'h000, info_reg}; // see [RQ13]
      end
      TAD_IDX_CONFIG: begin
        rd_data = {14'h0000, cfg_reg};
      end
      default: begin
        rd_data = 16'h0000;
      end
    endcase
  end

  // ack one cycle after the request, data captured with it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= acc;
      if (acc && !wb_we_i) begin
        dat_reg <= {16'h0000, rd_data};
      end
    end
  end

  // writable registers, low byte lane only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= TAD_MASK_RESET;
      cfg_reg <= TAD_CONFIG_RESET;
    end else begin
      if (wr_mask && wb_sel_i[0]) begin
        mask_reg[7:0] <= {1'b0, wb_dat_i[6:0]};
      end
      if (wr_cfg && wb_sel_i[0]) begin
        cfg_reg <= wb_dat_i[1:0];
      end
    end
  end

  // ==========================================================
  // t3 information field pattern checks
  logic info_en;
  logic field_end;
  logic [1:0] pos_cur;
  logic [2:0] ten_now;
  logic [2:0] quad_now;
  logic ten_ok;
  logic quad_ok;
  always_comb begin
    info_en = rx.bit_en & rx.info_bit;
    field_end = info_en & rx.info_last;
    pos_cur = rx.info_first ? 2'h0 : pos_reg;
    ten_now = sat_err(rx.info_first ? 3'h0 : ten_err_reg, rx.data == pos_cur[0]);
    quad_now = sat_err(rx.info_first ? 3'h0 : quad_err_reg, rx.data == pos_cur[1]);
    ten_ok = ten_now < TAD_PAT_ERR_LIMIT;
    quad_ok = quad_now < TAD_PAT_ERR_LIMIT;
  end

  // bit position and error tallies inside the field
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_reg <= 2'h0;
      ten_err_reg <= 3'h0;
      quad_err_reg <= 3'h0;
    end else if (info_en) begin
      pos_reg <= pos_cur + 2'h1;
      ten_err_reg <= ten_now;
      quad_err_reg <= quad_now;
    end
  end

  // c bit majority per group of three
  logic [1:0] c_now;
  logic c_one;
  assign c_now = c_ones_reg + {1'b0, rx.c_bit};
  assign c_one = rx.c_valid & rx.c_last & (c_now >= 2'h2);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      c_ones_reg <= 2'h0;
    end else if (rx.c_valid) begin
      c_ones_reg <= rx.c_last ? 2'h0 : c_now;
    end
  end

  // field run counters
  logic ais_on_t3;
  logic ais_off_t3;
  logic idle_on;
  logic idle_off;
  tad_run_counter #(.LIMIT(TAD_PAT_FIELDS)) u_ais_on (
    .ref_clk(ref_clk), .rst_n(rst_n), .clr(c_one), // see [RQ1]
    .step(field_end), .hit(ten_ok), .done(ais_on_t3)
  );
  tad_run_counter #(.LIMIT(TAD_PAT_FIELDS)) u_ais_off (
    .ref_clk(ref_clk), .rst_n(rst_n), .clr(1'b0), // see [RQ2]
    .step(field_end), .hit(~ten_ok), .done(ais_off_t3)
  );
  tad_run_counter #(.LIMIT(TAD_PAT_FIELDS)) u_idle_on (
    .ref_clk(ref_clk), .rst_n(rst_n), .clr(c_one & rx.c_sub3), // see [RQ7]
    .step(field_end), .hit(quad_ok), .done(idle_on)
  );
  tad_run_counter #(.LIMIT(TAD_PAT_FIELDS)) u_idle_off (
    .ref_clk(ref_clk), .rst_n(rst_n), .clr(1'b0), // see [RQ8]
    .step(field_end), .hit(~quad_ok), .done(idle_off)
  );

  // ==========================================================
  // remote alarm, evaluated at each frame start in both modes
  logic rai_on;
  logic rai_off;
  logic rai_on_hit;
  logic rai_off_hit;
  assign rai_on_hit = e3 ? rx.bit11 : (~rx.x1 & ~rx.x2); // see [RQ6] [RQ12]
  assign rai_off_hit = e3 ? ~rx.bit11 : (rx.x1 & rx.x2);
  tad_run_counter #(.LIMIT(TAD_RAI_FRAMES)) u_rai_on (
    .ref_clk(ref_clk), .rst_n(rst_n), .clr(1'b0),
    .step(rx.frame_start), .hit(rai_on_hit), .done(rai_on)
  );
  tad_run_counter #(.LIMIT(TAD_RAI_FRAMES)) u_rai_off (
    .ref_clk(ref_clk), .rst_n(rst_n), .clr(1'b0),
    .step(rx.frame_start), .hit(rai_off_hit), .done(rai_off)
  );

  // e3 frame alignment word runs
  logic lof_on_e3;
  logic lof_off_e3;
  tad_run_counter #(.LIMIT(TAD_E3_LOF_BAD)) u_lof_bad (
    .ref_clk(ref_clk), .rst_n(rst_n), .clr(1'b0), // see [RQ11]
    .step(rx.fas_valid), .hit(~rx.fas_ok), .done(lof_on_e3)
  );
  tad_run_counter #(.LIMIT(TAD_E3_LOF_GOOD)) u_lof_good (
    .ref_clk(ref_clk), .rst_n(rst_n), .clr(1'b0), // see [RQ11]
    .step(rx.fas_valid), .hit(rx.fas_ok), .done(lof_off_e3)
  );

  // ==========================================================
  // t3 f and m bit error windows
  logic sync_rise;
  logic [15:0] f_next;
  logic [3:0] m_next;
  logic lof_on_t3;
  always_comb begin
    sync_rise = rx.sync & ~sync_d_reg;
    f_next = {f_win_reg[14:0], rx.f_err};
    m_next = {m_win_reg[2:0], rx.m_err};
    lof_on_t3 = (rx.f_valid & (popcnt(f_next) >= TAD_F_ERR_LIMIT))
      | (rx.m_valid & (popcnt({12'h000, m_next}) >= TAD_M_ERR_LIMIT)); // see [RQ5]
  end

  // windows restart on each reacquired sync
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      f_win_reg <= 16'h0000;
      m_win_reg <= 4'h0;
    end else if (sync_rise) begin
      f_win_reg <= 16'h0000;
      m_win_reg <= 4'h0;
    end else begin
      if (rx.f_valid) begin
        f_win_reg <= f_next;
      end
      if (rx.m_valid) begin
        m_win_reg <= m_next;
      end
    end
  end

  // ==========================================================
  // e3 zero count over two frames
  logic [3:0] zpair;
  logic e3_ais_on;
  logic e3_ais_off;
  always_comb begin
    zpair = {1'b0, zprev_reg} + {1'b0, zcur_reg};
    e3_ais_on = rx.frame_start & zprev_ok_reg & (zpair <= TAD_E3_AIS_MAX_ZEROS); // see [RQ9]
    e3_ais_off = rx.frame_start & zprev_ok_reg & (zpair > TAD_E3_AIS_MAX_ZEROS); // see [RQ10]
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      zcur_reg <= 3'h0;
      zprev_reg <= 3'h0;
      zprev_ok_reg <= 1'b0;
    end else if (rx.frame_start) begin
      zprev_reg <= zcur_reg;
      zprev_ok_reg <= 1'b1;
      zcur_reg <= {2'h0, rx.bit_en & ~rx.data};
    end else if (rx.bit_en && !rx.data && zcur_reg != TAD_E3_ZERO_SAT) begin
      zcur_reg <= zcur_reg + 3'h1;
    end
  end

  // ==========================================================
  // zero runs, excess zero events and loss of signal window
  logic [7:0] run_next;
  logic [7:0] win_next;
  logic exz_evt;
  logic los_on;
  logic los_off;
  always_comb begin
    run_next = rx.mark ? 8'h00 : ((run_reg == 8'hff) ? run_reg : run_reg + 8'h01);
    exz_evt = rx.bit_en & ~rx.mark & (run_next == (e3 ? TAD_EXZ_E3 : TAD_EXZ_T3));
    win_next = (arm_reg ? win_reg : 8'h00) + 8'h01;
    los_on = rx.bit_en & (run_next == TAD_LOS_ZEROS); // see [RQ3]
    los_off = rx.bit_en & alarm_reg.los & (arm_reg | rx.mark) & ~exz_evt
      & (win_next == TAD_LOS_WINDOW); // see [RQ3]
  end

  // window opens on the first one, any excess zero closes it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= 8'h00;
      win_reg <= 8'h00;
      arm_reg <= 1'b0;
    end else if (rx.bit_en) begin
      run_reg <= run_next;
      if (!alarm_reg.los || exz_evt || los_off) begin
        arm_reg <= 1'b0;
        win_reg <= 8'h00;
      end else if (arm_reg || rx.mark) begin
        arm_reg <= 1'b1;
        win_reg <= win_next;
      end
    end
  end

  // ==========================================================
  // alarm states, mode selects the criteria
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_reg <= '0; // see [RQ22]
    end else begin
      if (unip) begin
        alarm_reg.los <= 1'b0; // see [RQ4]
      end else if (los_on) begin
        alarm_reg.los <= 1'b1;
      end else if (los_off) begin
        alarm_reg.los <= 1'b0;
      end
      if (e3 ? lof_on_e3 : lof_on_t3) begin
        alarm_reg.lof <= 1'b1;
      end else if (e3 ? lof_off_e3 : sync_rise) begin
        alarm_reg.lof <= 1'b0; // see [RQ5]
      end
      if (e3 ? e3_ais_on : ais_on_t3) begin
        alarm_reg.ais <= 1'b1;
      end else if (e3 ? e3_ais_off : ais_off_t3) begin
        alarm_reg.ais <= 1'b0;
      end
      if (rai_on) begin
        alarm_reg.rai <= 1'b1;
      end else if (rai_off) begin
        alarm_reg.rai <= 1'b0;
      end
      if (e3 || idle_off) begin
        alarm_reg.idle <= 1'b0;
      end else if (idle_on) begin
        alarm_reg.idle <= 1'b1;
      end
    end
  end

  // ==========================================================
  // sync history for alignment change
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_d_reg <= 1'b0;
      synced_reg <= 1'b0;
      align_reg <= '0;
    end else begin
      sync_d_reg <= rx.sync;
      if (sync_rise) begin
        synced_reg <= 1'b1;
        align_reg <= rx.align;
      end
    end
  end

  // event sources of the information register
  logic [4:0] info_set;
  always_comb begin
    info_set = 5'h00;
    info_set[TAD_BIT_ALIGN_CHANGE] = sync_rise & synced_reg
      & (rx.align != align_reg); // see [RQ14] [RQ15]
    info_set[TAD_BIT_CODEWORD] = rx.codeword; // see [RQ16]
    info_set[TAD_BIT_FRAMING_ERR] = e3 ? (rx.fas_valid & ~rx.fas_ok)
      : (rx.f_valid & rx.f_err); // see [RQ17]
    info_set[TAD_BIT_M_ERR] = ~e3 & rx.m_valid & rx.m_err; // see [RQ18]
    info_set[TAD_BIT_EXCESS_ZERO] = exz_evt; // see [RQ19]
  end

  // clear on read, a new event in the same cycle wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      info_reg <= 5'h00;
      sof_reg <= 1'b0;
      sof_req_reg <= 1'b0;
    end else begin
      info_reg <= (info_reg & ~{5{rd_info}}) | info_set; // see [RQ14] [RQ16]
      sof_reg <= (sof_reg & ~rd_status) | rx.frame_start; // see [RQ21]
      sof_req_reg <= sof_reg & mask_reg[TAD_BIT_RX_SOF]; // see [RQ20]
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign alarm_o = alarm_reg;
  assign rx_sof_req_o = sof_req_reg;

endmodule : tad_alarm_detector

/* tad_alarm_detector_chk.sv */
// checker of the t3/e3 alarm detector, bound to its ports
// assumes one clock and a classic wishbone master holding to ack
module tad_alarm_detector_chk
  import tad_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire tad_rx_t rx,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire tad_alarm_t alarm_o,
  input wire logic rx_sof_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // shadows of config, mask bit 6 and run counts
  logic taken;
  logic wr_cfg;
  logic e3_reg, unip_reg, m6_reg, rd_stat_reg;
  logic [7:0] zrun_reg;
  logic [2:0] rai_reg;
  assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_cfg = taken && wb_we_i && wb_sel_i[0];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      e3_reg <= 1'b0;
      unip_reg <= 1'b0;
      m6_reg <= 1'b0;
      rd_stat_reg <= 1'b0;
      zrun_reg <= 8'h00;
      rai_reg <= 3'h0;
    end else begin
      rd_stat_reg <= taken && !wb_we_i && wb_adr_i == {TAD_IDX_STATUS, 2'h0};
      if (wr_cfg && wb_adr_i == {TAD_IDX_CONFIG, 2'h0}) begin
        e3_reg <= wb_dat_i[TAD_BIT_E3_MODE];
        unip_reg <= wb_dat_i[TAD_BIT_UNIPOLAR];
      end
      if (wr_cfg && wb_adr_i == {TAD_IDX_MASK, 2'h0}) begin
        m6_reg <= wb_dat_i[TAD_BIT_RX_SOF];
      end
      if (rx.bit_en) begin
        zrun_reg <= rx.mark ? 8'h00 : zrun_reg + {7'h00, zrun_reg != 8'hff};
      end
      if (rx.frame_start) begin
        rai_reg <= (e3_reg || rx.x1 || rx.x2) ? 3'h0 : rai_reg + {2'h0, rai_reg != 3'h7};
      end
    end
  end
  // ==========================================================
  // properties
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_taken;
    taken;
  endsequence
  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_pulse_a: assert property (s_taken |=> s_ack_once)
    else $error("ack not a single pulse one cycle after request");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  status_view_a: assert property (
    rd_stat_reg && wb_ack_o |-> wb_dat_o[5:0] == {1'h0, $past(alarm_o)})
    else $error("status read differs from alarm levels");
  los_set_a: assert property (
    rx.bit_en && !rx.mark && zrun_reg == 8'hbf && !unip_reg |=> alarm_o.los)
    else $error("loss of signal not set after zero run");
  los_unipolar_a: assert property (unip_reg |=> !alarm_o.los)
    else $error("loss of signal in unipolar mode");
  idle_e3_a: assert property (e3_reg |=> !alarm_o.idle)
    else $error("idle raised in e3 mode");
  rai_set_a: assert property (
    rx.frame_start && !e3_reg && !rx.x1 && !rx.x2 && rai_reg == 3'h3 |=> alarm_o.rai)
    else $error("remote alarm not set after four frames");
  lof_sync_a: assert property (
    $rose(rx.sync) && !e3_reg && !rx.f_valid && !rx.m_valid |=> !alarm_o.lof)
    else $error("loss of frame kept after resync");
  sof_mask_a: assert property (!m6_reg && !$past(m6_reg) |-> !rx_sof_req_o)
    else $error("frame start request while masked");
endmodule : tad_alarm_detector_chk

bind tad_alarm_detector tad_alarm_detector_chk u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .rx(rx), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .alarm_o(alarm_o), .rx_sof_req_o(rx_sof_req_o)
);

/* tad_line_model.sv */
// receive framer model: drives the line strobes of the detector
// assumes strobes are one-cycle pulses on ref_clk
module tad_line_model
  import tad_pkg::*;
(
  input wire logic ref_clk,
  output tad_rx_t rx
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rx = '0;
  // ==========================================================
  // one strobe cycle, then idle; returns after the answer edge
  task automatic pulse(input tad_rx_t v);
    tad_rx_t z;
    z = '0;
    @(posedge ref_clk);
    v.sync = rx.sync;
    v.align = rx.align;
    rx <= v;
    @(posedge ref_clk);
    z.sync = rx.sync;
    z.align = rx.align;
    z.mark = ~rx.mark; // unqualified line shows no stale bit
    z.data = ~rx.data;
    rx <= z;
    @(negedge ref_clk);
  endtask : pulse
  // line bits, all marks or all zeros
  task automatic bits(input int n, input logic m);
    tad_rx_t v;
    v = '0;
    v.bit_en = 1'b1;
    v.mark = m;
    v.data = m;
    repeat (n) pulse(v);
  endtask : bits
  // sync level change, returns after the edge that sees it
  task automatic set_sync(input logic s, input logic [TAD_ALIGN_W-1:0] a);
    @(posedge ref_clk);
    rx.sync <= s;
    rx.align <= a;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : set_sync
endmodule : tad_line_model

/* tad_alarm_detector_tb_top.sv */
// testbench of the t3/e3 alarm detector: register and line scenarios
// assumes the line model drives rx and the checker is bound in
module tad_alarm_detector_tb_top
  import tad_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  tad_alarm_t alarm_o;
  logic rx_sof_req_o;
  tad_rx_t rx;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #12.5 ref_clk = ~ref_clk;
  tad_alarm_detector u_tad_alarm_detector (
    .ref_clk(ref_clk), .rst_n(rst_n), .rx(rx), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .alarm_o(alarm_o), .rx_sof_req_o(rx_sof_req_o)
  );
  tad_line_model u_tad_line_model (.ref_clk(ref_clk), .rx(rx));
  // ==========================================================
  // verdict, comparisons and bus tasks
  task automatic print_verdict;
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_reg
  task automatic chk_flag(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_flag
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                         output logic [31:0] rd);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= 4'hf;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_xfer
  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] x;
    wb_xfer(1'b1, adr, wd, x);
  endtask : wr
  task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] x;
    wb_xfer(1'b0, adr, 32'h0, x);
    chk_reg(name, exp, x);
  endtask : rd_chk
  // frame boundary, x selects inactive (1) or active (0) remote alarm bits
  task automatic frame(input logic x);
    tad_rx_t v;
    v = '0;
    v.frame_start = 1'b1;
    v.x1 = x;
    v.x2 = x;
    v.bit11 = ~x;
    u_tad_line_model.pulse(v);
  endtask : frame
  // 0 codeword, 1 f bit, 2 m bit, 3 alignment word; ok gives a good check
  task automatic ev(input int k, input logic ok);
    tad_rx_t v;
    v = '0;
    v.codeword = (k == 0);
    v.f_valid = (k == 1);
    v.m_valid = (k == 2);
    v.fas_valid = (k == 3);
    v.f_err = ~ok;
    v.m_err = ~ok;
    v.fas_ok = ok;
    u_tad_line_model.pulse(v);
  endtask : ev
  // ==========================================================
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict;
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk("mask", 8'h50, 32'h0);
    rd_chk("config", 8'h60, 32'h0);
    rd_chk("info", 8'h58, 32'h0);
    rd_chk("status", 8'h48, 32'h0);
    rd_chk("unmapped", 8'h7c, 32'h0);
    wr(8'h58, 32'hffff);
    rd_chk("info_ro", 8'h58, 32'h0);
    wr(8'h50, 32'hffff);
    rd_chk("mask_rw", 8'h50, 32'h7f);
    frame(1'b1);
    @(negedge ref_clk);
    chk_flag("sof_req", 1'b1, rx_sof_req_o);
    rd_chk("status_sof", 8'h48, 32'h40);
    rd_chk("status_clr", 8'h48, 32'h0);
    wr(8'h50, 32'h3f);
    frame(1'b1);
    @(negedge ref_clk);
    chk_flag("sof_masked", 1'b0, rx_sof_req_o);
    ev(0, 1'b0);
    ev(1, 1'b0);
    ev(2, 1'b0);
    u_tad_line_model.bits(1, 1'b1);
    u_tad_line_model.bits(2, 1'b0);
    u_tad_line_model.bits(1, 1'b1);
    rd_chk("info_ev", 8'h58, 32'h0e);
    u_tad_line_model.bits(3, 1'b0);
    u_tad_line_model.bits(1, 1'b1);
    rd_chk("info_exz", 8'h58, 32'h10);
    u_tad_line_model.set_sync(1'b1, 11'h005);
    repeat (3) ev(1, 1'b0);
    chk_flag("lof_f", 1'b1, alarm_o.lof);
    u_tad_line_model.set_sync(1'b0, 11'h005);
    u_tad_line_model.set_sync(1'b1, 11'h009);
    chk_flag("lof_sync", 1'b0, alarm_o.lof);
    rd_chk("info_alignment_change_event", 8'h58, 32'h05);
    u_tad_line_model.set_sync(1'b0, 11'h009);
    u_tad_line_model.set_sync(1'b1, 11'h009);
    rd_chk("info_same", 8'h58, 32'h0);
    repeat (2) ev(2, 1'b0);
    chk_flag("lof_m", 1'b1, alarm_o.lof);
    u_tad_line_model.set_sync(1'b0, 11'h009);
    u_tad_line_model.set_sync(1'b1, 11'h009);
    rd_chk("info_m", 8'h58, 32'h08);
    u_tad_line_model.bits(191, 1'b0);
    chk_flag("los_191", 1'b0, alarm_o.los);
    u_tad_line_model.bits(1, 1'b0);
    chk_flag("los_192", 1'b1, alarm_o.los);
    u_tad_line_model.bits(191, 1'b1);
    chk_flag("los_hold", 1'b1, alarm_o.los);
    u_tad_line_model.bits(1, 1'b1);
    chk_flag("los_clr", 1'b0, alarm_o.los);
    wr(8'h60, 32'h2);
    u_tad_line_model.bits(192, 1'b0);
    chk_flag("los_unipolar", 1'b0, alarm_o.los);
    wr(8'h60, 32'h0);
    u_tad_line_model.bits(1, 1'b1);
    repeat (3) frame(1'b0);
    chk_flag("rai_3", 1'b0, alarm_o.rai);
    frame(1'b0);
    chk_flag("rai_4", 1'b1, alarm_o.rai);
    repeat (4) frame(1'b1);
    chk_flag("rai_clr", 1'b0, alarm_o.rai);
    wr(8'h60, 32'h1);
    rd_chk("info_los", 8'h58, 32'h10);
    repeat (3) ev(3, 1'b0);
    chk_flag("e3_lof_3", 1'b0, alarm_o.lof);
    ev(3, 1'b0);
    chk_flag("e3_lof_4", 1'b1, alarm_o.lof);
    repeat (2) ev(3, 1'b1);
    chk_flag("e3_lof_hold", 1'b1, alarm_o.lof);
    ev(3, 1'b1);
    chk_flag("e3_lof_clr", 1'b0, alarm_o.lof);
    ev(2, 1'b0);
    rd_chk("info_e3", 8'h58, 32'h04);
    repeat (4) frame(1'b0);
    chk_flag("e3_rai", 1'b1, alarm_o.rai);
    chk_flag("e3_ais", 1'b1, alarm_o.ais);
    repeat (4) frame(1'b1);
    chk_flag("e3_rai_clr", 1'b0, alarm_o.rai);
    u_tad_line_model.bits(5, 1'b0);
    frame(1'b1);
    chk_flag("e3_ais_clr", 1'b0, alarm_o.ais);
    print_verdict;
  end
endmodule : tad_alarm_detector_tb_top
